// >>> rtl/flag_and_cmov_decode.sv
// decode and execute slice: widening, flag clears, carry invert, unsigned moves
// assumes: fetch presents one byte per valid/ready beat; register file reads src
// on o_src_sel and supplies i_src_data; flags held outside arrive on i_cf/i_zf
// Function
// - 99 sign-widens eax into edx, two clocks
// - F8 clears carry, one clock
// - FC clears direction, four clocks
// - FA clears interrupt enable, six clocks
// - 0F 06 clears task switched, seven clocks
// - F5 inverts carry, three clocks
// - 0F 47 moves when above, one clock
// - 0F 46 moves when below or equal
// - 0F 43 moves when above or equal
// - 0F 42 moves when below
`timescale 1ns/1ps
`default_nettype none
`include "flag_cmov_defs.svh"
module flag_and_cmov_decode (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_byte_valid,
   input  wire logic [7:0]  i_byte,
   output logic             o_byte_ready,
   input  wire logic [31:0] i_eax,
   input  wire logic [31:0] i_src_data,
   input  wire logic        i_cf,
   input  wire logic        i_zf,
   output logic [2:0]       o_src_sel,
   output logic             o_src_is_mem,
   output logic             o_busy,
   output logic             o_edx_wr,
   output logic [31:0]      o_edx_data,
   output logic             o_dst_wr,
   output logic [2:0]       o_dst_sel,
   output logic [31:0]      o_dst_data,
   output logic             o_cf_wr,
   output logic             o_cf_val,
   output logic             o_df_clr,
   output logic             o_if_clr,
   output logic             o_ts_clr,
   output logic             o_retire,
   output logic             o_undefined
);

   function automatic flag_cmov_pkg::op_e decode_one(input logic [7:0] b);
      if (b == `OPC_WIDEN)       decode_one = flag_cmov_pkg::OP_WIDEN;
      else if (b == `OPC_CLR_CF) decode_one = flag_cmov_pkg::OP_CLR_CF;
      else if (b == `OPC_CLR_DF) decode_one = flag_cmov_pkg::OP_CLR_DF;
      else if (b == `OPC_CLR_IF) decode_one = flag_cmov_pkg::OP_CLR_IF;
      else if (b == `OPC_INV_CF) decode_one = flag_cmov_pkg::OP_INV_CF;
      else                       decode_one = flag_cmov_pkg::OP_NONE;
   endfunction

   function automatic flag_cmov_pkg::op_e decode_two(input logic [7:0] b);
      if (b == `OPC2_CLR_TS)     decode_two = flag_cmov_pkg::OP_CLR_TS;
      else if (b == `OPC2_MOV_A || b == `OPC2_MOV_BE || b == `OPC2_MOV_AE || b == `OPC2_MOV_B)
                                 decode_two = flag_cmov_pkg::OP_CMOV;
      else                       decode_two = flag_cmov_pkg::OP_NONE;
   endfunction

   function automatic flag_cmov_pkg::cond_e cond_of(input logic [7:0] b);
      if (b == `OPC2_MOV_A)       cond_of = flag_cmov_pkg::COND_A;
      else if (b == `OPC2_MOV_BE) cond_of = flag_cmov_pkg::COND_BE;
      else if (b == `OPC2_MOV_AE) cond_of = flag_cmov_pkg::COND_AE;
      else                        cond_of = flag_cmov_pkg::COND_B;
   endfunction

   function automatic logic [2:0] cycles_of(input flag_cmov_pkg::op_e op);
      case (op)
         flag_cmov_pkg::OP_WIDEN:  cycles_of = `CYC_WIDEN;
         flag_cmov_pkg::OP_CLR_CF: cycles_of = `CYC_CLR_CF;
         flag_cmov_pkg::OP_CLR_DF: cycles_of = `CYC_CLR_DF;
         flag_cmov_pkg::OP_CLR_IF: cycles_of = `CYC_CLR_IF;
         flag_cmov_pkg::OP_CLR_TS: cycles_of = `CYC_CLR_TS;
         flag_cmov_pkg::OP_INV_CF: cycles_of = `CYC_INV_CF;
         default:                  cycles_of = `CYC_CMOV;
      endcase
   endfunction

   flag_cmov_pkg::dec_state_e state_q, state_d;
   flag_cmov_pkg::op_e        op_q, op_d;
   flag_cmov_pkg::cond_e      cond_q, cond_d;
   logic [2:0]                cnt_q, cnt_d;
   logic [7:0]                modrm_q;
   logic [3:0]                len_q;

   cond_if cif ();
   cmov_cond u_cond (
      .c (cif)
   );

   wire logic                 take_byte  = i_byte_valid & o_byte_ready;
   wire logic                 is_escape  = i_byte == `OPC_ESCAPE;
   wire flag_cmov_pkg::op_e   one_op     = decode_one(i_byte);
   wire flag_cmov_pkg::op_e   two_op     = decode_two(i_byte);
   wire logic                 exec_last  = (state_q == flag_cmov_pkg::ST_EXEC) && (cnt_q == `RST_CNT);
   // loads come from the byte itself, not op_d, so next-state logic never feeds itself
   wire logic [2:0]           load_one   = cycles_of(one_op) - 3'h1;
   wire logic [2:0]           load_two   = cycles_of(two_op) - 3'h1;

   assign o_byte_ready = state_q != flag_cmov_pkg::ST_EXEC;
   assign o_busy       = state_q != flag_cmov_pkg::ST_OPCODE;
   assign o_src_sel    = modrm_q[`MODRM_RM_HI:`MODRM_RM_LO];
   assign o_src_is_mem = modrm_q[`MODRM_MOD_HI:`MODRM_MOD_LO] != 2'b11;
   assign cif.sel      = cond_q;
   assign cif.cf       = i_cf;
   assign cif.zf       = i_zf;

   // next state; an unknown byte drops back to the first opcode byte
   always_comb begin
      state_d = state_q;
      op_d    = op_q;
      cond_d  = cond_q;
      cnt_d   = cnt_q;
      case (state_q)
         flag_cmov_pkg::ST_OPCODE: begin
            if (take_byte && is_escape) begin
               state_d = flag_cmov_pkg::ST_ESCAPE;
            end else if (take_byte && one_op != flag_cmov_pkg::OP_NONE) begin
               op_d    = one_op;
               state_d = flag_cmov_pkg::ST_EXEC;
               cnt_d   = load_one;
            end
         end
         flag_cmov_pkg::ST_ESCAPE: begin
            if (take_byte) begin
               op_d   = two_op;
               cond_d = cond_of(i_byte);
               cnt_d  = load_two;
               if (two_op == flag_cmov_pkg::OP_CMOV) begin
                  state_d = flag_cmov_pkg::ST_MODRM;
               end else if (two_op == flag_cmov_pkg::OP_CLR_TS) begin
                  state_d = flag_cmov_pkg::ST_EXEC;
               end else begin
                  state_d = flag_cmov_pkg::ST_OPCODE;
               end
            end
         end
         flag_cmov_pkg::ST_MODRM: begin
            if (take_byte) begin
               state_d = flag_cmov_pkg::ST_EXEC;
            end
         end
         default: begin
            if (exec_last) begin
               state_d = flag_cmov_pkg::ST_OPCODE;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_q <= flag_cmov_pkg::ST_OPCODE;
         op_q    <= flag_cmov_pkg::OP_NONE;
         cond_q  <= flag_cmov_pkg::COND_A;
         cnt_q   <= `RST_CNT;
      end else begin
         state_q <= state_d;
         op_q    <= op_d;
         cond_q  <= cond_d;
         cnt_q   <= cnt_d;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         modrm_q <= `RST_BYTE;
      end else if (take_byte && state_q == flag_cmov_pkg::ST_MODRM) begin
         modrm_q <= i_byte;
      end
   end

   // undefined opcode report, one pulse per rejected byte
   wire logic undef_one = take_byte && state_q == flag_cmov_pkg::ST_OPCODE && !is_escape
                          && one_op == flag_cmov_pkg::OP_NONE;
   wire logic undef_two = take_byte && state_q == flag_cmov_pkg::ST_ESCAPE
                          && two_op == flag_cmov_pkg::OP_NONE;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_undefined <= 1'b0;
      end else begin
         o_undefined <= undef_one | undef_two;
      end
   end

   // effects land together with the retire pulse; other flags are never touched
   wire logic [31:0] sign_fill = {32{i_eax[31]}};
   wire logic        is_cmov   = op_q == flag_cmov_pkg::OP_CMOV;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_retire <= 1'b0;
         o_edx_wr <= 1'b0;
         o_dst_wr <= 1'b0;
         o_cf_wr  <= 1'b0;
         o_df_clr <= 1'b0;
         o_if_clr <= 1'b0;
         o_ts_clr <= 1'b0;
      end else begin
         o_retire <= exec_last;
         o_edx_wr <= exec_last && op_q == flag_cmov_pkg::OP_WIDEN;
         o_cf_wr  <= exec_last && (op_q == flag_cmov_pkg::OP_CLR_CF || op_q == flag_cmov_pkg::OP_INV_CF);
         o_df_clr <= exec_last && op_q == flag_cmov_pkg::OP_CLR_DF;
         o_if_clr <= exec_last && op_q == flag_cmov_pkg::OP_CLR_IF;
         o_ts_clr <= exec_last && op_q == flag_cmov_pkg::OP_CLR_TS;
         o_dst_wr <= exec_last && is_cmov && cif.take;
      end
   end

   // data lanes are only meaningful alongside their write strobes
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_edx_data <= `RST_WORD;
         o_dst_data <= `RST_WORD;
         o_dst_sel  <= 3'h0;
         o_cf_val   <= 1'b0;
      end else if (exec_last) begin
         o_edx_data <= sign_fill;
         o_dst_data <= i_src_data;
         o_dst_sel  <= modrm_q[`MODRM_REG_HI:`MODRM_REG_LO];
         o_cf_val   <= (op_q == flag_cmov_pkg::OP_INV_CF) ? ~i_cf : 1'b0;
      end
   end

   // helper: cycles spent in execute, read by the checks only
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         len_q <= `RST_LEN;
      end else if (state_q != flag_cmov_pkg::ST_EXEC) begin
         len_q <= `RST_LEN;
      end else begin
         len_q <= len_q + 4'h1;
      end
   end

   chk_widen_timing: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_retire && op_q == flag_cmov_pkg::OP_WIDEN |-> len_q == {1'b0, `CYC_WIDEN} && o_edx_wr && !o_cf_wr)
      else $error("widen retire timing or effect wrong");

   chk_widen_data: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_edx_wr |-> o_edx_data == {32{$past(i_eax[31])}})
      else $error("widen sign fill wrong");

   chk_clr_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_retire && op_q == flag_cmov_pkg::OP_CLR_CF |-> len_q == {1'b0, `CYC_CLR_CF} && o_cf_wr && !o_cf_val
         && !o_df_clr && !o_if_clr && !o_ts_clr)
      else $error("carry clear wrong");

   chk_clr_direction: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      take_byte && state_q == flag_cmov_pkg::ST_OPCODE && i_byte == `OPC_CLR_DF
         |=> (!o_retire && !o_df_clr) [*4] ##1 (o_retire && o_df_clr && !o_cf_wr))
      else $error("direction clear not four clocks");

   chk_clr_interrupt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_if_clr |-> len_q == {1'b0, `CYC_CLR_IF} && o_retire && !o_cf_wr && !o_df_clr)
      else $error("interrupt clear wrong");

   chk_clr_task_sw: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      take_byte && state_q == flag_cmov_pkg::ST_ESCAPE && i_byte == `OPC2_CLR_TS
         |=> (!o_retire && !o_byte_ready) [*7] ##1 (o_ts_clr && o_retire))
      else $error("task switched clear not seven clocks");

   chk_inv_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_retire && op_q == flag_cmov_pkg::OP_INV_CF |-> len_q == {1'b0, `CYC_INV_CF} && o_cf_wr
         && o_cf_val == !$past(i_cf))
      else $error("carry invert wrong");

   chk_move_above: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_retire && is_cmov && cond_q == flag_cmov_pkg::COND_A |-> len_q == 4'h1
         && o_dst_wr == $past(!i_cf && !i_zf) && !o_cf_wr)
      else $error("above move wrong");

   chk_move_below_eq: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_retire && is_cmov && cond_q == flag_cmov_pkg::COND_BE |-> o_dst_wr == $past(i_cf || i_zf))
      else $error("below or equal move wrong");

   chk_move_above_eq: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_retire && is_cmov && cond_q == flag_cmov_pkg::COND_AE |-> o_dst_wr == $past(!i_cf))
      else $error("above or equal move wrong");

   chk_move_below: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_retire && is_cmov && cond_q == flag_cmov_pkg::COND_B |-> o_dst_wr == $past(i_cf)
         && (!o_dst_wr || o_dst_data == $past(i_src_data)))
      else $error("below move wrong");

   chk_escape_map: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      take_byte && state_q == flag_cmov_pkg::ST_OPCODE && is_escape
         |=> state_q == flag_cmov_pkg::ST_ESCAPE && !o_retire)
      else $error("escape byte not taken into two-byte map");

   chk_undef_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_undefined |-> state_q == flag_cmov_pkg::ST_OPCODE && !o_retire && !o_busy)
      else $error("rejected byte did not drop back to opcode stage");

endmodule
`default_nettype wire

// >>> rtl/flag_cmov_defs.svh
// opcode bytes, cycle counts and reset values for the flag and conditional move decoder
// assumes: included by bare name from files under rtl/
`ifndef FLAG_CMOV_DEFS_SVH
`define FLAG_CMOV_DEFS_SVH

`define OPC_ESCAPE   8'h0F
`define OPC_WIDEN    8'h99
`define OPC_CLR_CF   8'hF8
`define OPC_CLR_DF   8'hFC
`define OPC_CLR_IF   8'hFA
`define OPC_INV_CF   8'hF5
`define OPC2_CLR_TS  8'h06
`define OPC2_MOV_A   8'h47
`define OPC2_MOV_BE  8'h46
`define OPC2_MOV_AE  8'h43
`define OPC2_MOV_B   8'h42

`define CYC_WIDEN    3'h2
`define CYC_CLR_CF   3'h1
`define CYC_CLR_DF   3'h4
`define CYC_CLR_IF   3'h6
`define CYC_CLR_TS   3'h7
`define CYC_INV_CF   3'h3
`define CYC_CMOV     3'h1

`define RST_CNT      3'h0
`define RST_LEN      4'h0
`define RST_BYTE     8'h00
`define RST_WORD     32'h0000_0000

`define MODRM_MOD_HI 7
`define MODRM_MOD_LO 6
`define MODRM_REG_HI 5
`define MODRM_REG_LO 3
`define MODRM_RM_HI  2
`define MODRM_RM_LO  0

`endif

// >>> rtl/flag_cmov_pkg.sv
// types shared by the flag and conditional move decoder
// assumes: nothing beyond the compiler
package flag_cmov_pkg;

   typedef enum logic [1:0] {
      ST_OPCODE = 2'b00,
      ST_ESCAPE = 2'b01,
      ST_MODRM  = 2'b10,
      ST_EXEC   = 2'b11
   } dec_state_e;

   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_WIDEN  = 3'b001,
      OP_CLR_CF = 3'b010,
      OP_CLR_DF = 3'b011,
      OP_CLR_IF = 3'b100,
      OP_CLR_TS = 3'b101,
      OP_INV_CF = 3'b110,
      OP_CMOV   = 3'b111
   } op_e;

   typedef enum logic [1:0] {
      COND_A  = 2'b00,
      COND_BE = 2'b01,
      COND_AE = 2'b10,
      COND_B  = 2'b11
   } cond_e;

endpackage

// >>> rtl/cond_if.sv
// carries the move condition select and flags to the condition evaluator
// assumes: both ends on the same core clock, purely combinational path
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
   flag_cmov_pkg::cond_e sel;
   logic                 cf;
   logic                 zf;
   logic                 take;
   modport decoder   (output sel, output cf, output zf, input take);
   modport evaluator (input sel, input cf, input zf, output take);
endinterface
`default_nettype wire

// >>> rtl/cmov_cond.sv
// evaluates the unsigned move conditions from carry and zero
// assumes: flags are stable for the cycle in which take is sampled
`timescale 1ns/1ps
`default_nettype none
module cmov_cond (
   cond_if.evaluator c
);
   wire logic above = ~c.cf & ~c.zf;

   always_comb begin
      case (c.sel)
         flag_cmov_pkg::COND_A:  c.take = above;
         flag_cmov_pkg::COND_BE: c.take = ~above;
         flag_cmov_pkg::COND_AE: c.take = ~c.cf;
         default:                c.take = c.cf;
      endcase
   end
endmodule
`default_nettype wire

// >>> dv/fetch_regfile_model.sv
// far side model: fetch byte stream on valid/ready and a small register file with flags
// assumes: one core clock; the block strobes writes for one cycle, together with retire
`timescale 1ns/1ps
`default_nettype none
module fetch_regfile_model #(
   parameter logic [31:0] MEM_WORD = 32'h5A5A_A5A5
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_byte_ready,
   output logic             o_byte_valid,
   output logic [7:0]       o_byte,
   output logic [31:0]      o_eax,
   output logic [31:0]      o_src_data,
   output logic             o_cf,
   output logic             o_zf,
   input  wire logic [2:0]  i_src_sel,
   input  wire logic        i_src_is_mem,
   input  wire logic        i_edx_wr,
   input  wire logic [31:0] i_edx_data,
   input  wire logic        i_dst_wr,
   input  wire logic [2:0]  i_dst_sel,
   input  wire logic [31:0] i_dst_data,
   input  wire logic        i_cf_wr,
   input  wire logic        i_cf_val,
   input  wire logic        i_df_clr,
   input  wire logic        i_if_clr,
   input  wire logic        i_ts_clr
);
   logic [7:0]  q[$];
   logic [31:0] regs[8];
   logic        cf_q, zf_q, df_q, ief_q, ts_q;
   int          cyc, t_take;
   assign o_eax      = regs[0];
   assign o_src_data = i_src_is_mem ? MEM_WORD : regs[i_src_sel];
   assign o_cf       = cf_q;
   assign o_zf       = zf_q;
   initial begin
      o_byte_valid = 1'b0;
      o_byte = 8'h00;
      cyc = 0;
      t_take = 0;
      foreach (regs[i]) regs[i] = 32'h0000_0000;
      {cf_q, zf_q, df_q, ief_q, ts_q} = 5'h00;
   end
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask
   always @(posedge i_clk_sys) begin
      cyc = cyc + 1;
      if (!i_rst && o_byte_valid && i_byte_ready) begin
         void'(q.pop_front());
         t_take = cyc;
      end
      if (i_edx_wr) regs[2] <= i_edx_data;
      if (i_dst_wr) regs[i_dst_sel] <= i_dst_data;
      if (i_cf_wr) cf_q <= i_cf_val;
      if (i_df_clr) df_q <= 1'b0;
      if (i_if_clr) ief_q <= 1'b0;
      if (i_ts_clr) ts_q <= 1'b0;
      #1;
      // an idle byte lane toggles so a stale byte is never mistaken for a fresh one
      if (q.size() > 0) begin
         o_byte_valid = 1'b1;
         o_byte = q[0];
      end else begin
         o_byte_valid = 1'b0;
         o_byte = ~o_byte;
      end
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the flag and conditional move decoder
// assumes: fetch_regfile_model on the far side, inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_sys, rst, byte_valid, byte_ready, cf, zf, src_is_mem, busy;
   logic        edx_wr, dst_wr, cf_wr, cf_val, df_clr, if_clr, ts_clr, retire, undefined;
   logic [7:0]  fbyte;
   logic [2:0]  src_sel, dst_sel;
   logic [31:0] eax, src_data, edx_data, dst_data;
   int          num_errors, compares;

   flag_and_cmov_decode dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_byte_valid(byte_valid), .i_byte(fbyte),
      .o_byte_ready(byte_ready), .i_eax(eax), .i_src_data(src_data), .i_cf(cf), .i_zf(zf),
      .o_src_sel(src_sel), .o_src_is_mem(src_is_mem), .o_busy(busy), .o_edx_wr(edx_wr),
      .o_edx_data(edx_data), .o_dst_wr(dst_wr), .o_dst_sel(dst_sel), .o_dst_data(dst_data),
      .o_cf_wr(cf_wr), .o_cf_val(cf_val), .o_df_clr(df_clr), .o_if_clr(if_clr), .o_ts_clr(ts_clr),
      .o_retire(retire), .o_undefined(undefined));
   fetch_regfile_model m (.i_clk_sys(clk_sys), .i_rst(rst), .i_byte_ready(byte_ready),
      .o_byte_valid(byte_valid), .o_byte(fbyte), .o_eax(eax), .o_src_data(src_data), .o_cf(cf),
      .o_zf(zf), .i_src_sel(src_sel), .i_src_is_mem(src_is_mem), .i_edx_wr(edx_wr),
      .i_edx_data(edx_data), .i_dst_wr(dst_wr), .i_dst_sel(dst_sel), .i_dst_data(dst_data),
      .i_cf_wr(cf_wr), .i_cf_val(cf_val), .i_df_clr(df_clr), .i_if_clr(if_clr), .i_ts_clr(ts_clr));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // latency is counted from the edge that took the final byte; one more edge lets writes land
   task automatic wait_done(input int lat);
      int   n;
      logic hb;
      n = 0;
      hb = 1'b0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
         if (retire !== 1'b1) hb = hb | busy;
      end while (retire !== 1'b1 && n < 40);
      chk("retire", 32'h1, {31'h0, retire});
      chk("latency", lat, m.cyc - m.t_take);
      chk("busy_exec", 32'h1, {31'h0, hb});
      chk("busy_idle", 32'h0, {31'h0, busy});
      @(posedge clk_sys);
      #1;
   endtask

   task automatic flags(input logic [3:0] exp);
      chk("cf_df_if_ts", {28'h0, exp}, {28'h0, m.cf_q, m.df_q, m.ief_q, m.ts_q});
   endtask

   task automatic s_widen;
      {m.cf_q, m.df_q, m.ief_q, m.ts_q} = 4'hF;
      m.regs[0] = 32'h8000_0001;
      m.push(8'h99);
      wait_done(2);
      chk("edx", 32'hFFFF_FFFF, m.regs[2]);
      m.regs[0] = 32'h7FFF_FFFF;
      m.regs[2] = 32'h1234_5678;
      m.push(8'h99);
      wait_done(2);
      chk("edx", 32'h0000_0000, m.regs[2]);
      flags(4'hF);
   endtask

   task automatic s_flags;
      m.push(8'hF8);
      m.push(8'hF5);
      wait_done(1);
      flags(4'h7);
      wait_done(3);
      flags(4'hF);
      m.push(8'hFC);
      wait_done(4);
      flags(4'hB);
      m.push(8'hFA);
      wait_done(6);
      flags(4'h9);
      m.push(8'h0F);
      m.push(8'h06);
      wait_done(7);
      flags(4'h8);
   endtask

   task automatic s_cmov;
      logic [7:0] ops[4];
      logic       take;
      ops = '{8'h47, 8'h46, 8'h43, 8'h42};
      for (int i = 0; i < 4; i++) begin
         for (int f = 0; f < 4; f++) begin
            {m.cf_q, m.zf_q} = f[1:0];
            m.regs[5] = 32'hA000_0000 | (i * 4 + f);
            m.regs[3] = 32'h0000_0000;
            take = (i == 0) ? (f == 0) : (i == 1) ? (f != 0) : (i == 2) ? !f[1] : f[1];
            m.push(8'h0F);
            m.push(ops[i]);
            m.push(8'hDD);
            wait_done(1);
            chk("dst", take ? m.regs[5] : 32'h0, m.regs[3]);
            chk("cf_zf", f, {m.cf_q, m.zf_q});
         end
      end
      m.cf_q = 1'b1;
      m.push(8'h0F);
      m.push(8'h42);
      m.push(8'h18);
      wait_done(1);
      chk("src_is_mem", 32'h1, {31'h0, src_is_mem});
      chk("dst_mem", 32'h5A5A_A5A5, m.regs[3]);
   endtask

   // unknown bytes are dropped and decoding restarts at an opcode byte
   task automatic s_undef;
      logic [7:0] bad[2];
      int         n;
      bad = '{8'h90, 8'h44};
      for (int i = 0; i < 2; i++) begin
         if (i == 1) m.push(8'h0F);
         m.push(bad[i]);
         n = 0;
         do begin
            @(posedge clk_sys);
            #1;
            n++;
         end while (undefined !== 1'b1 && n < 20);
         chk("undefined", 32'h1, {31'h0, undefined});
         chk("no_retire", 32'h0, {31'h0, retire});
      end
      m.cf_q = 1'b1;
      m.push(8'hF8);
      wait_done(1);
      chk("cf", 32'h0, {31'h0, m.cf_q});
   endtask

   task automatic complete_run;
      if (num_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      num_errors = 0;
      compares = 0;
      rst = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 rst = 1'b0;
      s_widen;
      s_flags;
      s_cmov;
      s_undef;
      complete_run;
   end

   // all scenarios finish within a few hundred cycles
   initial begin
      #100000;
      num_errors++;
      complete_run;
   end
endmodule
`default_nettype wire
